// >>> rtl/sprl_pkg.sv
// package: constants, carriers and codes for the stack pop and single instruction loop block
package sprl_pkg;

  // ==================================================================
  // widths
  localparam int DATA_W = 16;
  localparam int LC_W = 13;
  localparam int IMM_W = 6;
  localparam int DEST_W = 5;
  localparam int RADDR_W = 4;
  localparam int TIMER_W = 3;

  // ==================================================================
  // timing in core clock cycles
  localparam int POP_CYCLES = 2;
  localparam int REP_CYCLES = 6;
  localparam logic [TIMER_W-1:0] REP_WAIT = TIMER_W'(REP_CYCLES - 1);
  // the loop instruction and the repeated instruction are one word each
  localparam logic [DATA_W-1:0] PROG_WORD = 16'h0001;

  // ==================================================================
  // saturation constants placed by the limiter
  localparam logic [DATA_W-1:0] SAT_POS = 16'h7fff;
  localparam logic [DATA_W-1:0] SAT_NEG = 16'h8000;

  // ==================================================================
  // register offsets, fields and reset values
  localparam logic [RADDR_W-1:0] OFS_SP = 4'h0;
  localparam logic [RADDR_W-1:0] OFS_LC = 4'h4;
  localparam logic [RADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [RADDR_W-1:0] OFS_HELD = 4'hc;
  localparam int STAT_LIMIT_BIT = 0;
  localparam int STAT_LOOP_BIT = 1;
  localparam logic [DATA_W-1:0] SP_RST = 16'h0000;
  localparam logic [LC_W-1:0] LC_RST = 13'h0000;

  // ==================================================================
  // operations handed over by the decoder
  typedef enum logic [1:0] {
    OP_POP_REG = 2'h0,
    OP_POP_NONE = 2'h1,
    OP_LOOP_IMM = 2'h2,
    OP_LOOP_REG = 2'h3
  } sprl_op_e;

  typedef struct packed {
    logic valid;
    sprl_op_e op;
    logic [DATA_W-1:0] pc;
    logic [IMM_W-1:0] imm;
    logic [DATA_W-1:0] src;
    logic src_acc;
    logic acc_ext;
    logic acc_neg;
    logic [DEST_W-1:0] dest;
  } sprl_issue_s;

  typedef struct packed {
    logic valid;
    logic [DEST_W-1:0] dest;
    logic [DATA_W-1:0] data;
  } sprl_wb_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_POP = 6'b00_0010,
    ST_LOAD = 6'b00_0100,
    ST_FETCH = 6'b00_1000,
    ST_EXEC = 6'b01_0000,
    ST_DONE = 6'b10_0000
  } sprl_state_e;

endpackage : sprl_pkg

// >>> rtl/sprl_count_src.sv
// module: loop count selection with accumulator saturation
`timescale 1ns/1ps
module sprl_count_src (
  input wire sprl_pkg::sprl_issue_s issue, // decoded loop instruction
  output logic [sprl_pkg::LC_W-1:0] count, // value for the loop counter
  output logic saturated // limiter substituted a constant
);

  logic [sprl_pkg::DATA_W-1:0] bus_val;

  // ==================================================================
  // source mux and limiter
  always_comb
  begin
    bus_val = issue.src;
    saturated = 1'b0;
    if (issue.op == sprl_pkg::OP_LOOP_IMM)
    begin
      bus_val = {{(sprl_pkg::DATA_W-sprl_pkg::IMM_W){1'b0}}, issue.imm};
    end
    else if (issue.src_acc && issue.acc_ext)
    begin
      saturated = 1'b1;
      bus_val = issue.acc_neg ? sprl_pkg::SAT_NEG : sprl_pkg::SAT_POS;
    end
    count = bus_val[sprl_pkg::LC_W-1:0];
  end

endmodule : sprl_count_src

// >>> rtl/sprl_cycle_timer.sv
// module: down counter that marks the last cycle of a fixed instruction time
`timescale 1ns/1ps
module sprl_cycle_timer #(
  parameter int W = sprl_pkg::TIMER_W
) (
  input wire logic clock, // core clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic load, // start a new interval
  input wire logic [W-1:0] load_val, // cycles to run after the load cycle
  output logic done // last cycle of the interval
);

  typedef struct packed {
    logic [W-1:0] count;
  } sprl_timer_s;

  sprl_timer_s s_q;
  sprl_timer_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (load)
    begin
      s_d.count = load_val;
    end
    else if (s_q.count != '0)
    begin
      s_d.count = s_q.count - W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign done = (s_q.count == W'(1));

  chk_timer_ends: assert property (@(posedge clock) disable iff (!rst_n)
    load && load_val == W'(5) |=> !done [*4] ##1 done) else $error("timer end wrong");

endmodule : sprl_cycle_timer

// >>> rtl/sprl_core.sv
// module: stack pop and single instruction loop control for the core pipeline
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - pop reads stack word, then decrements pointer
// - pop without destination only decrements pointer
// - pop leaves condition codes untouched
// - pop takes two cycles, one word
// - loop count is thirteen bits, unsigned
// - repeated instruction fetched once, held
// - interrupts held off until loop ends
// - execute per count, stop after count one
// - old counter saved, restored at loop end
// - zero count skips the repeated instruction
// - immediate fills six bits, clears seven
// - register source gives low thirteen bits
// - positive extended accumulator gives all ones
// - negative extended accumulator gives zero count
// - saturation sets limit flag, accumulators kept
// - loop instruction takes six cycles, one word
module sprl_core (
  input wire logic clock, // core clock, 125 MHz
  input wire logic rst_n, // asynchronous reset, active low
  input wire sprl_pkg::sprl_issue_s issue, // decoded instruction offer
  output logic issue_ready, // block can take an instruction
  output logic mem_rd_en, // data memory read strobe
  output logic [sprl_pkg::DATA_W-1:0] mem_addr, // data memory address
  input wire logic [sprl_pkg::DATA_W-1:0] mem_rd_data, // read word, cycle after strobe
  output sprl_pkg::sprl_wb_s wb, // register file write back
  output logic fetch_req, // request the word to repeat
  output logic [sprl_pkg::DATA_W-1:0] fetch_addr, // address of that word
  input wire logic fetch_valid, // fetched word present
  input wire logic [sprl_pkg::DATA_W-1:0] fetch_word, // fetched word
  output logic [sprl_pkg::DATA_W-1:0] held_instr, // instruction register
  output logic exec_pulse, // one execution of the held word
  output logic irq_hold, // interrupts blocked
  output logic resume_valid, // loop finished, refetch
  output logic [sprl_pkg::DATA_W-1:0] resume_addr, // address to refetch from
  output logic [sprl_pkg::LC_W-1:0] loop_counter, // current loop counter
  output logic limit_flag, // condition code limit bit
  input wire logic [sprl_pkg::RADDR_W-1:0] reg_addr, // register address
  input wire logic [sprl_pkg::DATA_W-1:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [sprl_pkg::DATA_W-1:0] reg_rdata // read data, cycle after strobe
);

  typedef struct packed {
    sprl_pkg::sprl_state_e state;
    logic has_dest;
    logic [sprl_pkg::DEST_W-1:0] dest;
    logic [sprl_pkg::DATA_W-1:0] stack_pointer;
    logic [sprl_pkg::LC_W-1:0] loop_counter;
    logic [sprl_pkg::LC_W-1:0] lc_saved;
    logic limit;
    logic [sprl_pkg::DATA_W-1:0] instr;
    logic [sprl_pkg::DATA_W-1:0] loop_pc;
    sprl_pkg::sprl_wb_s wb;
    logic [sprl_pkg::DATA_W-1:0] rdata;
  } sprl_core_s;

  sprl_core_s s_q;
  sprl_core_s s_d;
  logic [sprl_pkg::LC_W-1:0] new_count;
  logic saturated;
  logic take;
  logic take_pop;
  logic take_loop;
  logic timer_done;

  // ==================================================================
  // helpers
  function automatic logic is_loop_op(input sprl_pkg::sprl_op_e op);
    return (op == sprl_pkg::OP_LOOP_IMM) || (op == sprl_pkg::OP_LOOP_REG);
  endfunction : is_loop_op

  function automatic logic hit(input logic [sprl_pkg::RADDR_W-1:0] a,
                               input logic [sprl_pkg::RADDR_W-1:0] ofs);
    return a == ofs;
  endfunction : hit

  // ==================================================================
  // issue handshake
  assign issue_ready = (s_q.state == sprl_pkg::ST_IDLE);
  assign take = issue.valid && issue_ready;
  assign take_loop = take && is_loop_op(issue.op);
  assign take_pop = take && !is_loop_op(issue.op);

  sprl_count_src u_count (
    .issue(issue),
    .count(new_count),
    .saturated(saturated)
  );

  sprl_cycle_timer #(
    .W(sprl_pkg::TIMER_W)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .load(take_loop),
    .load_val(sprl_pkg::REP_WAIT),
    .done(timer_done)
  );

  // ==================================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.wb.valid = 1'b0;
    s_d.rdata = '0;
    unique case (s_q.state)
      sprl_pkg::ST_IDLE:
      begin
        if (take_pop)
        begin
          // the read goes out now; the pointer moves once the word is back
          s_d.has_dest = (issue.op == sprl_pkg::OP_POP_REG);
          s_d.dest = issue.dest;
          s_d.state = sprl_pkg::ST_POP;
        end
        else if (take_loop)
        begin
          s_d.lc_saved = s_q.loop_counter;
          s_d.loop_counter = new_count;
          s_d.loop_pc = issue.pc;
          // accumulators are never written here, only the limit bit
          s_d.limit = s_q.limit | saturated;
          s_d.state = sprl_pkg::ST_LOAD;
        end
      end
      sprl_pkg::ST_POP:
      begin
        s_d.wb.valid = s_q.has_dest;
        s_d.wb.dest = s_q.dest;
        s_d.wb.data = mem_rd_data;
        s_d.stack_pointer = s_q.stack_pointer - sprl_pkg::PROG_WORD;
        s_d.state = sprl_pkg::ST_IDLE; // limit bit left as it was
      end
      sprl_pkg::ST_LOAD:
      begin
        if (timer_done)
        begin
          s_d.state = sprl_pkg::ST_FETCH;
        end
      end
      sprl_pkg::ST_FETCH:
      begin
        if (fetch_valid)
        begin
          s_d.instr = fetch_word;
          s_d.state = (s_q.loop_counter == '0) ? sprl_pkg::ST_DONE : sprl_pkg::ST_EXEC;
        end
      end
      sprl_pkg::ST_EXEC:
      begin
        s_d.loop_counter = s_q.loop_counter - sprl_pkg::LC_W'(1);
        if (s_q.loop_counter == sprl_pkg::LC_W'(1))
        begin
          s_d.state = sprl_pkg::ST_DONE;
        end
      end
      sprl_pkg::ST_DONE:
      begin
        s_d.loop_counter = s_q.lc_saved;
        s_d.state = sprl_pkg::ST_IDLE;
      end
      default:
      begin
        s_d.state = sprl_pkg::ST_IDLE;
      end
    endcase

    // stack pointer and loop counter writes only land while the pipeline is idle
    // and nothing is taken, so they never race the hardware updates of the same register
    if (reg_wr && s_q.state == sprl_pkg::ST_IDLE && !take)
    begin
      if (hit(reg_addr, sprl_pkg::OFS_SP))
      begin
        s_d.stack_pointer = reg_wdata;
      end
      if (hit(reg_addr, sprl_pkg::OFS_LC))
      begin
        s_d.loop_counter = reg_wdata[sprl_pkg::LC_W-1:0];
      end
    end
    // limit bit is write one to clear; a new saturation wins over the clear
    if (reg_wr && hit(reg_addr, sprl_pkg::OFS_STATUS) && reg_wdata[sprl_pkg::STAT_LIMIT_BIT])
    begin
      s_d.limit = take_loop & saturated;
    end

    if (reg_rd)
    begin
      if (hit(reg_addr, sprl_pkg::OFS_SP))
      begin
        s_d.rdata = s_q.stack_pointer;
      end
      else if (hit(reg_addr, sprl_pkg::OFS_LC))
      begin
        s_d.rdata = {{(sprl_pkg::DATA_W-sprl_pkg::LC_W){1'b0}}, s_q.loop_counter};
      end
      else if (hit(reg_addr, sprl_pkg::OFS_STATUS))
      begin
        s_d.rdata[sprl_pkg::STAT_LIMIT_BIT] = s_q.limit;
        s_d.rdata[sprl_pkg::STAT_LOOP_BIT] = irq_hold;
      end
      else if (hit(reg_addr, sprl_pkg::OFS_HELD))
      begin
        s_d.rdata = s_q.instr;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.state <= sprl_pkg::ST_IDLE;
      s_q.has_dest <= 1'b0;
      s_q.dest <= '0;
      s_q.stack_pointer <= sprl_pkg::SP_RST;
      s_q.loop_counter <= sprl_pkg::LC_RST;
      s_q.lc_saved <= sprl_pkg::LC_RST;
      s_q.limit <= 1'b0;
      s_q.instr <= '0;
      s_q.loop_pc <= '0;
      s_q.wb <= '0;
      s_q.rdata <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==================================================================
  // outputs
  assign mem_rd_en = take_pop;
  assign mem_addr = s_q.stack_pointer;
  assign wb = s_q.wb;
  assign fetch_req = (s_q.state == sprl_pkg::ST_FETCH);
  assign fetch_addr = s_q.loop_pc + sprl_pkg::PROG_WORD;
  assign held_instr = s_q.instr;
  assign exec_pulse = (s_q.state == sprl_pkg::ST_EXEC);
  assign irq_hold = !(s_q.state inside {sprl_pkg::ST_IDLE, sprl_pkg::ST_POP});
  assign resume_valid = (s_q.state == sprl_pkg::ST_DONE);
  assign resume_addr = s_q.loop_pc + sprl_pkg::PROG_WORD + sprl_pkg::PROG_WORD;
  assign loop_counter = s_q.loop_counter;
  assign limit_flag = s_q.limit;
  assign reg_rdata = s_q.rdata;

  // ==================================================================
  // checks
  logic [sprl_pkg::LC_W-1:0] chk_old_lc;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chk_old_lc <= '0;
    end
    else if (take_loop)
    begin
      chk_old_lc <= s_q.loop_counter;
    end
  end

  chk_pop_order: assert property (@(posedge clock) disable iff (!rst_n)
    take_pop |-> mem_rd_en && mem_addr == s_q.stack_pointer
      ##2 s_q.stack_pointer == $past(mem_addr, 2) - 16'h0001) else $error("pop order wrong");
  chk_pop_nodest: assert property (@(posedge clock) disable iff (!rst_n)
    take_pop && issue.op == sprl_pkg::OP_POP_NONE |-> ##2 !wb.valid) else $error("pop wrote");
  chk_pop_flags: assert property (@(posedge clock) disable iff (!rst_n)
    take_pop && !reg_wr |=> $stable(limit_flag)) else $error("pop changed flags");
  chk_pop_time: assert property (@(posedge clock) disable iff (!rst_n)
    take_pop |=> !issue_ready ##1 issue_ready) else $error("pop not two cycles");
  chk_loop_time: assert property (@(posedge clock) disable iff (!rst_n)
    take_loop |=> !fetch_req [*5] ##1 fetch_req) else $error("loop not six cycles");
  chk_imm_high: assert property (@(posedge clock) disable iff (!rst_n)
    take_loop && issue.op == sprl_pkg::OP_LOOP_IMM |=>
      loop_counter == {7'h00, $past(issue.imm)}) else $error("immediate count wrong");
  chk_irq_block: assert property (@(posedge clock) disable iff (!rst_n)
    exec_pulse |-> irq_hold ##1 $stable(held_instr)) else $error("loop not protected");
  chk_last_exec: assert property (@(posedge clock) disable iff (!rst_n)
    exec_pulse && loop_counter == 13'h0001 |=> resume_valid && !exec_pulse) else
    $error("loop end wrong");
  chk_zero_skip: assert property (@(posedge clock) disable iff (!rst_n)
    fetch_req && fetch_valid && loop_counter == 13'h0000 |=> resume_valid && !exec_pulse) else
    $error("zero count executed");
  chk_lc_restore: assert property (@(posedge clock) disable iff (!rst_n)
    resume_valid |=> loop_counter == chk_old_lc) else $error("counter not restored");
  chk_sat_flag: assert property (@(posedge clock) disable iff (!rst_n)
    take_loop && issue.op == sprl_pkg::OP_LOOP_REG &&
      issue.src_acc && issue.acc_ext && !issue.acc_neg |=>
      limit_flag && loop_counter == 13'h1fff) else $error("saturation wrong");
  // an immediate count never goes through the limiter, so only the register form counts
  chk_sat_neg: assert property (@(posedge clock) disable iff (!rst_n)
    take_loop && issue.op == sprl_pkg::OP_LOOP_REG &&
      issue.src_acc && issue.acc_ext && issue.acc_neg |=>
      limit_flag && loop_counter == 13'h0000) else $error("negative saturation wrong");
  chk_resume_pc: assert property (@(posedge clock) disable iff (!rst_n)
    take_loop |=> resume_addr == $past(issue.pc) + 16'h0002) else $error("resume address wrong");

endmodule : sprl_core

// >>> testbench/sprl_partner.sv
// partner model: data memory and instruction stream behind the block
`timescale 1ns/1ps
module sprl_partner (
  input wire logic clock, // core clock
  input wire logic mem_rd_en, // read strobe
  input wire logic [15:0] mem_addr, // read address
  output logic [15:0] mem_rd_data, // word, cycle after strobe
  input wire logic fetch_req, // fetch request
  input wire logic [15:0] fetch_addr, // fetch address
  output logic fetch_valid, // word offered
  output logic [15:0] fetch_word, // offered word
  input wire logic [3:0] stall // cycles a fetch is stalled
);
  logic [3:0] wait_q = 4'h0;
  logic [15:0] rd_q = 16'h0000;
  // ==================================================================
  // data memory: contents follow the address so the bench can predict them
  always @(posedge clock)
  begin
    if (mem_rd_en)
      rd_q <= mem_addr ^ 16'ha5a5;
    else
      rd_q <= ~rd_q; // word is only valid for one cycle
  end
  assign mem_rd_data = rd_q;
  // ==================================================================
  // instruction stream, prompt or slow
  always @(posedge clock)
  begin
    if (fetch_req && !fetch_valid)
      wait_q <= wait_q + 4'h1;
    else
      wait_q <= 4'h0;
  end
  assign fetch_valid = fetch_req && (wait_q >= stall);
  // offered words are one-word instructions that keep program flow
  assign fetch_word = fetch_valid ? (fetch_addr ^ 16'h3c00) : ~fetch_addr;
endmodule : sprl_partner

// >>> testbench/test_sprl_core.sv
// testbench: stack pop and single instruction loop scenarios
`timescale 1ns/1ps
module test_sprl_core;
  logic clock;
  logic rst_n;
  logic issue_ready, mem_rd_en, fetch_req, fetch_valid, exec_pulse, irq_hold;
  logic resume_valid, limit_flag, reg_wr, reg_rd;
  logic [15:0] mem_addr, mem_rd_data, fetch_addr, fetch_word, held_instr, resume_addr;
  logic [15:0] reg_wdata, reg_rdata, rd;
  logic [12:0] loop_counter;
  logic [3:0] reg_addr, stall;
  logic [3:0] ofs [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
  sprl_pkg::sprl_issue_s issue;
  sprl_pkg::sprl_wb_s wb;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;

  sprl_core i_sprl_core (.clock(clock), .rst_n(rst_n), .issue(issue),
    .issue_ready(issue_ready), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
    .mem_rd_data(mem_rd_data), .wb(wb), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .held_instr(held_instr),
    .exec_pulse(exec_pulse), .irq_hold(irq_hold), .resume_valid(resume_valid),
    .resume_addr(resume_addr), .loop_counter(loop_counter), .limit_flag(limit_flag),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  sprl_partner i_sprl_partner (.clock(clock), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
    .mem_rd_data(mem_rd_data), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .stall(stall));

  // ==================================================================
  // clock and hang guard
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      summarize();
    end
  end
  // ==================================================================
  // tasks
  task summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write
  task reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask : reg_read
  // offer held until taken; returns in the take cycle
  task offer(input sprl_pkg::sprl_issue_s s);
    @(posedge clock);
    issue <= s;
    @(negedge clock);
    while (issue_ready !== 1'b1)
      @(negedge clock);
  endtask : offer
  task pop(input logic has, input logic [15:0] sp);
    sprl_pkg::sprl_issue_s s;
    s = '0;
    s.valid = 1'b1;
    s.op = has ? sprl_pkg::OP_POP_REG : sprl_pkg::OP_POP_NONE;
    s.dest = 5'h07;
    offer(s);
    check(16'(mem_rd_en), 16'h0001, "pop strobe");
    check(mem_addr, sp, "pop address");
    @(posedge clock);
    issue.valid <= 1'b0;
    @(negedge clock);
    check(16'(wb.valid), 16'h0000, "early write back");
    @(negedge clock);
    check(16'(wb.valid), 16'(has), "write back");
    if (has)
    begin
      check(16'(wb.dest), 16'h0007, "pop destination");
      check(wb.data, sp ^ 16'ha5a5, "pop data");
    end
    check(16'(issue_ready), 16'h0001, "pop length");
    check(16'(limit_flag), 16'h0000, "flags after pop");
  endtask : pop
  task run(input sprl_pkg::sprl_op_e op, input logic [5:0] imm, input logic [15:0] src,
           input logic [2:0] acc, input int cnt, input logic lim);
    sprl_pkg::sprl_issue_s s;
    int n;
    int execs;
    int fetches;
    int first;
    s = '0;
    s.valid = 1'b1;
    s.op = op;
    s.pc = 16'h0200;
    s.imm = imm;
    s.src = src;
    {s.src_acc, s.acc_ext, s.acc_neg} = acc;
    n = 0;
    execs = 0;
    fetches = 0;
    first = 0;
    offer(s);
    @(posedge clock);
    issue.valid <= 1'b0;
    while (n < 9000)
    begin
      @(negedge clock);
      n++;
      check(16'(irq_hold), 16'h0001, "interrupt hold");
      if (fetch_req === 1'b1 && first == 0)
        first = n;
      if (fetch_req === 1'b1 && fetch_valid === 1'b1)
        fetches++;
      if (exec_pulse === 1'b1)
      begin
        check(16'(loop_counter), 16'(cnt - execs), "count per pass");
        check(held_instr, 16'h0201 ^ 16'h3c00, "held word");
        execs++;
      end
      if (resume_valid === 1'b1)
      begin
        check(resume_addr, 16'h0202, "resume address");
        n = 9000;
      end
    end
    check(16'(first), 16'd6, "loop instruction time");
    check(16'(fetches), 16'h0001, "fetches");
    check(16'(execs), 16'(cnt), "executions");
    check(16'(limit_flag), 16'(lim), "limit flag");
    @(negedge clock);
    check(16'(loop_counter), 16'h0099, "counter restored");
    check({15'h0, irq_hold}, 16'h0000, "interrupts released");
  endtask : run
  // ==================================================================
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    issue = '0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    stall = 4'h0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    foreach (ofs[i])
    begin
      reg_read(ofs[i], rd);
      check(rd, 16'h0000, "reset value");
    end
    $display("test registers done");
    reg_write(sprl_pkg::OFS_SP, 16'h0100);
    pop(1'b1, 16'h0100);
    pop(1'b0, 16'h00ff);
    reg_read(sprl_pkg::OFS_SP, rd);
    check(rd, 16'h00fe, "pointer after pops");
    $display("test pop done");
    // count sources are immediates, plain data registers or accumulators
    reg_write(sprl_pkg::OFS_LC, 16'h0099);
    run(sprl_pkg::OP_LOOP_IMM, 6'h03, 16'hffff, 3'b000, 3, 1'b0);
    run(sprl_pkg::OP_LOOP_IMM, 6'h3f, 16'hffff, 3'b000, 63, 1'b0);
    run(sprl_pkg::OP_LOOP_IMM, 6'h00, 16'h0005, 3'b000, 0, 1'b0);
    run(sprl_pkg::OP_LOOP_REG, 6'h3f, 16'he003, 3'b000, 3, 1'b0);
    run(sprl_pkg::OP_LOOP_REG, 6'h01, 16'h2000, 3'b000, 0, 1'b0);
    stall = 4'h3;
    run(sprl_pkg::OP_LOOP_REG, 6'h00, 16'h0002, 3'b101, 2, 1'b0);
    stall = 4'h0;
    $display("test loop done");
    run(sprl_pkg::OP_LOOP_REG, 6'h00, 16'h0004, 3'b110, 8191, 1'b1);
    reg_read(sprl_pkg::OFS_STATUS, rd);
    check(rd, 16'h0001, "status after limit");
    reg_write(sprl_pkg::OFS_STATUS, 16'h0001);
    reg_read(sprl_pkg::OFS_STATUS, rd);
    check(rd, 16'h0000, "status cleared");
    run(sprl_pkg::OP_LOOP_REG, 6'h00, 16'h0004, 3'b111, 0, 1'b1);
    $display("test saturation done");
    summarize();
  end
endmodule : test_sprl_core
